// [inc/bsr_pkg.sv]
// Package of the bus status and request/grant block: status codes,
// bus states and timing counts.
// Assumes a single clock domain; nothing here is shared across clocks.
package bsr_pkg;

  // ********************************************************
  // Cycle status codes, bit two first
  // ********************************************************
  localparam logic [2:0] CS_INT_ACK = 3'h0;
  localparam logic [2:0] CS_IO_READ = 3'h1;
  localparam logic [2:0] CS_IO_WRITE = 3'h2;
  localparam logic [2:0] CS_HALT = 3'h3;
  localparam logic [2:0] CS_CODE_FETCH = 3'h4;
  localparam logic [2:0] CS_MEM_READ = 3'h5;
  localparam logic [2:0] CS_MEM_WRITE = 3'h6;
  localparam logic [2:0] CS_PASSIVE = 3'h7;

  // ********************************************************
  // Timing count and number of request/grant lines
  // ********************************************************
  // Clocks during which a line ignores the echo of its own grant pulse
  localparam logic [1:0] ECHO_BLANK = 2'h3;
  localparam int NUM_LINES = 2;

  // ********************************************************
  // Bus states
  // ********************************************************
  typedef enum logic [6:0] {
    BS_IDLE = 7'h01,
    BS_FOUR = 7'h02,
    BS_ONE = 7'h04,
    BS_TWO = 7'h08,
    BS_THREE = 7'h10,
    BS_WAIT = 7'h20,
    BS_GRANTED = 7'h40
  } bsr_state_e;

endpackage

// [hdl/bsr_handover_line.sv]
// One request/grant line: synchroniser, low-pulse detector and grant driver.
// Assumes the line is pulled high by bus-hold when no one drives it.
`timescale 1ns/10ps
`default_nettype none

module bsr_handover_line
  import bsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic line_in,
  input wire logic grant_go,
  output logic req_seen,
  output logic line_out,
  output logic line_oe
);

  logic sync1;
  logic sync2;
  logic sync_prev;
  logic [1:0] blank;
  wire fall_seen = sync_prev & ~sync2;

  // ********************************************************
  // Input synchroniser and pulse detect
  // ********************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync_prev <= 1'b1;
    end else begin
      sync1 <= line_in;
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end

  // Our own grant pulse comes back through the synchroniser; mask it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      blank <= 2'h0;
      req_seen <= 1'b0;
    end else begin
      blank <= grant_go ? ECHO_BLANK : (blank != 2'h0 ? blank - 2'h1 : 2'h0);
      req_seen <= fall_seen & (blank == 2'h0) & ~grant_go;
    end
  end

  // ********************************************************
  // Grant driver: one clock low, then released to bus-hold
  // ********************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_oe <= 1'b0;
      line_out <= 1'b1;
    end else begin
      line_oe <= grant_go;
      line_out <= ~grant_go;
    end
  end

endmodule
`default_nettype wire

// [hdl/bsr_bus_status.sv]
// Bus status sequencer with two request/grant lines for the local bus.
// Assumes the ready pin and both lines are asynchronous; the core side is on mclk.
//
// Function
// - Status returns passive when ready sampled high
// - Status change in state four starts cycle
// - Passive in three or wait ends cycle
// - Status floats, held high, while granted
// - Bus released when current cycle ends
// - Lines bidirectional; first line wins ties
// - Lines held high by bus-hold when idle
// - Grant pulse one clock, state four or idle
`timescale 1ns/10ps
`default_nettype none

module bsr_bus_status
  import bsr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cyc_req,
  input wire logic [2:0] cyc_code,
  output logic cyc_taken,
  output logic cyc_end,
  output logic bus_granted,
  input wire logic ready_pin,
  output logic cycle_status_bit2,
  output logic cycle_status_bit1,
  output logic cycle_status_bit0,
  output logic cycle_status_oe,
  input wire logic bus_handover_line_high_prio_in,
  output logic bus_handover_line_high_prio_out,
  output logic bus_handover_line_high_prio_oe,
  input wire logic bus_handover_line_low_prio_in,
  output logic bus_handover_line_low_prio_out,
  output logic bus_handover_line_low_prio_oe
);

  bsr_state_e st;
  bsr_state_e next_st;
  logic [2:0] status;
  logic ready_meta;
  logic ready_s;
  logic [1:0] pend;
  logic gnt_sel;
  logic [1:0] req_seen;
  logic [1:0] line_in;
  logic [1:0] line_out;
  logic [1:0] line_oe;

  assign line_in = {bus_handover_line_low_prio_in, bus_handover_line_high_prio_in};
  assign bus_handover_line_high_prio_out = line_out[0];
  assign bus_handover_line_high_prio_oe = line_oe[0];
  assign bus_handover_line_low_prio_out = line_out[1];
  assign bus_handover_line_low_prio_oe = line_oe[1];
  assign cycle_status_bit2 = status[2];
  assign cycle_status_bit1 = status[1];
  assign cycle_status_bit0 = status[0];

  // ********************************************************
  // Decode
  // ********************************************************
  wire grant_slot = (st == BS_FOUR) || (st == BS_IDLE);
  wire [1:0] grant_go = grant_slot ? (pend[0] ? 2'h1 : {pend[1], 1'b0}) : 2'h0;
  wire release_seen = (st == BS_GRANTED) && req_seen[gnt_sel];
  // A passive code is no cycle, so such a request is never taken
  wire start_ok = cyc_req && (cyc_code != CS_PASSIVE) && (grant_go == 2'h0);
  wire ready_end = ((st == BS_THREE) || (st == BS_WAIT)) && ready_s;

  // ********************************************************
  // Request/grant lines
  // ********************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      bsr_handover_line u_line (
        .mclk(mclk),
        .rst_n(rst_n),
        .line_in(line_in[gi]),
        .grant_go(grant_go[gi]),
        .req_seen(req_seen[gi]),
        .line_out(line_out[gi]),
        .line_oe(line_oe[gi])
      );
      // The release pulse of the granted line is not a new request
      wire set_req = req_seen[gi] && !(st == BS_GRANTED && gnt_sel == 1'(gi));
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          pend[gi] <= 1'b0;
        end else begin
          pend[gi] <= set_req | (pend[gi] & ~grant_go[gi]);
        end
      end
    end
  endgenerate

  // ********************************************************
  // Ready synchroniser
  // ********************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready_meta <= 1'b0;
      ready_s <= 1'b0;
    end else begin
      ready_meta <= ready_pin;
      ready_s <= ready_meta;
    end
  end

  // ********************************************************
  // Bus state sequence
  // ********************************************************
  always_comb begin
    next_st = st;
    unique case (st)
      BS_IDLE: begin
        if (grant_go != 2'h0) begin
          next_st = BS_GRANTED;
        end else if (start_ok) begin
          next_st = BS_FOUR;
        end
      end
      BS_FOUR: begin
        if (grant_go != 2'h0) begin
          next_st = BS_GRANTED;
        end else if (start_ok) begin
          next_st = BS_ONE;
        end else begin
          next_st = BS_IDLE;
        end
      end
      BS_ONE: next_st = BS_TWO;
      BS_TWO: next_st = BS_THREE;
      BS_THREE: next_st = ready_s ? BS_FOUR : BS_WAIT;
      BS_WAIT: next_st = ready_s ? BS_FOUR : BS_WAIT;
      BS_GRANTED: next_st = release_seen ? BS_IDLE : BS_GRANTED;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= BS_IDLE;
      gnt_sel <= 1'b0;
    end else begin
      st <= next_st;
      if (grant_go != 2'h0) begin
        gnt_sel <= grant_go[1];
      end
    end
  end

  // ********************************************************
  // Status outputs
  // ********************************************************
  // The code goes out only in state four, so every start is seen there
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status <= CS_PASSIVE;
      cycle_status_oe <= 1'b1;
      cyc_taken <= 1'b0;
      cyc_end <= 1'b0;
      bus_granted <= 1'b0;
    end else begin
      cyc_taken <= (st == BS_FOUR) && start_ok;
      cyc_end <= ready_end;
      bus_granted <= (next_st == BS_GRANTED);
      if (ready_end || grant_go != 2'h0) begin
        status <= CS_PASSIVE;
      end else if (st == BS_FOUR && start_ok) begin
        status <= cyc_code;
      end
      if (grant_go != 2'h0) begin
        cycle_status_oe <= 1'b0;
      end else if (release_seen) begin
        cycle_status_oe <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_grant_pulse(int i);
    line_oe[i] && !line_out[i] ##1 !line_oe[i];
  endsequence

  a_ready_passive: assert property (ready_end |=> status == CS_PASSIVE && st == BS_FOUR)
    else $error("status not passive after ready");
  a_start_in_four: assert property (
    cycle_status_oe && $past(status) == CS_PASSIVE && status != CS_PASSIVE
    |-> $past(st) == BS_FOUR)
    else $error("cycle started outside state four");
  a_end_pulse: assert property (ready_end |=> cyc_end ##1 !cyc_end)
    else $error("cycle end not flagged");
  a_float_grant: assert property (
    bus_granted |-> !cycle_status_oe && status == CS_PASSIVE)
    else $error("status driven while granted");
  a_release_end: assert property (st == BS_FOUR && pend != 2'h0 |=> st == BS_GRANTED)
    else $error("bus not released at cycle end");
  a_prio_tie: assert property (pend == 2'h3 && grant_slot |=> line_oe[0] && !line_oe[1])
    else $error("low priority line won a tie");
  a_grant_high: assert property (grant_go[0] |=> s_grant_pulse(0))
    else $error("high line grant pulse wrong");
  a_grant_low: assert property (grant_go[1] |=> s_grant_pulse(1))
    else $error("low line grant pulse wrong");
  a_code_taken: assert property (
    cyc_taken |-> status == $past(cyc_code) && $past(st) == BS_FOUR)
    else $error("status code not the requested one");
  a_resume_next: assert property (release_seen |=> cycle_status_oe && st == BS_IDLE)
    else $error("bus not resumed after release");

endmodule
`default_nettype wire

// [testbench/bsr_far_end.sv]
// Far-end model: a bus controller that answers ready, and two masters that
// borrow the bus. Assumes the bench resolves the status pins and both lines.
`timescale 1ns/10ps
`default_nettype none
module bsr_far_end (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] status,
  input wire logic [1:0] wait_len,
  input wire logic [1:0] fire,
  input wire logic [1:0] line_lvl,
  output logic ready_pin,
  output logic [1:0] pull_low
);
  // ********************************
  // Controller ready and two masters
  // ********************************
  logic [2:0] cnt;
  logic [1:0] st [2];
  logic [2:0] hold [2];
  always @(posedge mclk) begin
    cnt <= (!rst_n || status == 3'h7) ? 3'h0 : cnt + {2'h0, cnt != 3'h7};
    // Ready is driven off the decoded status and the wait count against wait_len
    ready_pin <= rst_n && status != 3'h7 && cnt >= {1'b0, wait_len};
    for (int k = 0; k < 2; k++) begin
      if (!rst_n) begin
        st[k] <= 2'h0;
        pull_low[k] <= 1'b0;
      end else begin
        case (st[k])
          2'h0: if (fire[k]) begin
            pull_low[k] <= 1'b1;
            st[k] <= 2'h1;
          end
          2'h1: begin
            pull_low[k] <= 1'b0;
            if (!line_lvl[k] && !pull_low[k]) begin
              st[k] <= 2'h2;
              hold[k] <= 3'h6;
            end
          end
          2'h2: if (hold[k] == 3'h0) begin
            pull_low[k] <= 1'b1;
            st[k] <= 2'h3;
          end else begin
            hold[k] <= hold[k] - 3'h1;
          end
          default: begin
            pull_low[k] <= 1'b0;
            st[k] <= 2'h0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench of the bus status block with its far-end model.
// Assumes one 20 MHz clock; lines and status pins resolve to high when undriven.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import bsr_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, cyc_req = 1'b0, ready_pin;
  logic [2:0] cyc_code = 3'h0, status, code_q[$], grant_q[$];
  logic [1:0] wait_len = 2'h0, fire = 2'h0, pull_low, line_lvl;
  logic cyc_taken, cyc_end, bus_granted, cs_b2, cs_b1, cs_b0, s_oe, hp_out, hp_oe, lp_out, lp_oe;
  int err_count = 0, tests_run = 0, cycles = 0;
  logic [31:0] seed = 32'd92253;
  // Undriven pins are held high by bus-hold
  assign status = s_oe ? {cs_b2, cs_b1, cs_b0} : 3'h7;
  assign line_lvl = {!(pull_low[1] | (lp_oe & !lp_out)), !(pull_low[0] | (hp_oe & !hp_out))};
  // High only if a driven line is wrongly driven high
  wire drv_hi = (hp_oe & hp_out) | (lp_oe & lp_out);
  bsr_bus_status u_bsr_bus_status (.mclk(mclk), .rst_n(rst_n), .cyc_req(cyc_req),
    .cyc_code(cyc_code), .cyc_taken(cyc_taken), .cyc_end(cyc_end),
    .bus_granted(bus_granted), .ready_pin(ready_pin), .cycle_status_bit2(cs_b2),
    .cycle_status_bit1(cs_b1), .cycle_status_bit0(cs_b0), .cycle_status_oe(s_oe),
    .bus_handover_line_high_prio_in(line_lvl[0]), .bus_handover_line_high_prio_out(hp_out),
    .bus_handover_line_high_prio_oe(hp_oe), .bus_handover_line_low_prio_in(line_lvl[1]),
    .bus_handover_line_low_prio_out(lp_out), .bus_handover_line_low_prio_oe(lp_oe));
  bsr_far_end u_bsr_far_end (.mclk(mclk), .rst_n(rst_n), .status(status),
    .wait_len(wait_len), .fire(fire), .line_lvl(line_lvl), .ready_pin(ready_pin),
    .pull_low(pull_low));
  // ********************************
  // Helpers
  // ********************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(string name, logic [2:0] seen, logic [2:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask
  task automatic step();
    @(posedge mclk);
    #2;
  endtask
  task automatic wait_taken(int lim);
    int n = 0;
    do begin
      step();
      n++;
    end while (!cyc_taken && n < lim);
    check("taken", {2'h0, cyc_taken}, 3'h1);
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compared, %0d mismatched", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ********************************
  // Clock, watcher and stimulus
  // ********************************
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Outputs are sampled mid-cycle, where they have settled
  always @(negedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      end_of_test();
    end
    if (cyc_taken) check("code", status, code_q.size() ? code_q.pop_front() : 3'hX);
    if (cyc_end) check("end", status, CS_PASSIVE);
    if (hp_oe | lp_oe) begin
      check("line", {2'h0, lp_oe}, grant_q.size() ? grant_q.pop_front() : 3'hX);
      check("drive", {drv_hi, s_oe, bus_granted}, 3'h1);
      check("float", status, CS_PASSIVE);
      check("held", 3'(code_q.size()), 3'h1);
    end
  end
  initial begin
    repeat (16) step();
    rst_n = 1'b1;
    for (int i = 0; i < 24; i++) begin
      cyc_code = (i < 7) ? i[2:0] : 3'(rnd() % 7);
      wait_len = 2'(rnd());
      code_q.push_back(cyc_code);
      cyc_req = 1'b1;
      wait_taken(60);
    end
    $display("test back_to_back done");
    wait_len = 2'h3;
    cyc_code = CS_IO_READ;
    code_q.push_back(cyc_code);
    fire = 2'h3;
    grant_q.push_back(3'h0);
    grant_q.push_back(3'h1);
    step();
    fire = 2'h0;
    wait_taken(150);
    cyc_req = 1'b0;
    check("grants", 3'(grant_q.size()), 3'h0);
    $display("test grant_priority done");
    cyc_code = CS_PASSIVE;
    cyc_req = 1'b1;
    repeat (20) step();
    cyc_req = 1'b0;
    rst_n = 1'b0;
    repeat (3) step();
    check("rst", {s_oe, hp_oe, lp_oe}, 3'h4);
    check("rst_status", status, CS_PASSIVE);
    $display("test refuse_and_reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
